/* core/asp_defs.vh */
// register indexes, field positions, reset values and timing counts of the serial port
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
`define ASP_IDX_RESET 6'h00
`define ASP_IDX_TXDATA 6'h01
`define ASP_IDX_RXDATA 6'h02
`define ASP_IDX_RATE 6'h03
`define ASP_IDX_FORMAT 6'h04
`define ASP_IDX_MODEM 6'h05
`define ASP_IDX_LSTAT 6'h06
`define ASP_IDX_ISTAT 6'h07
`define ASP_IDX_IMASK 6'h08
`define ASP_IDX_ERR 6'h0a
`define ASP_RATE_RST 8'h50
`define ASP_FORMAT_RST 8'h03
`define ASP_FMT_LEN_LO 0
`define ASP_FMT_STOP 2
`define ASP_FMT_PEN 3
`define ASP_FMT_SENSE_LO 4
`define ASP_SENSE_ODD 2'h0
`define ASP_SENSE_EVEN 2'h1
`define ASP_SENSE_ONE 2'h2
`define ASP_SENSE_ZERO 2'h3
`define ASP_MDM_DTR 0
`define ASP_MDM_RTS 1
`define ASP_MDM_SRTS 2
`define ASP_MDM_DRS 3
`define ASP_ERR_PAR 0
`define ASP_ERR_FRM 1
`define ASP_ERR_OVR 2
`define ASP_ERR_BRK 3
`define ASP_INT_RXERR 0
`define ASP_INT_RXRDY 1
`define ASP_INT_TXDONE 2
`define ASP_OS_TICKS 5'h10
`define ASP_HALF_TICKS 4'h7
`define ASP_STOP1_TICKS 6'h10
`define ASP_STOP15_TICKS 6'h18
`define ASP_STOP2_TICKS 6'h20
`endif

/* core/asp_serial_port.v */
// asynchronous serial port with apb registers, one-character receive buffer and modem lines
`include "asp_defs.vh"
module asp_serial_port
(
	input wire sys_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire rxd,
	output reg txd,
	output wire rts,
	output wire dtr,
	output wire srts,
	output wire drs,
	output wire irq
);
	localparam TX_IDLE = 1'b0;
	localparam TX_SEND = 1'b1;
	localparam RX_IDLE = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_BITS = 2'h2;

	// parity bit that a frame must carry for the masked data
	function asp_par;
		input [7:0] d;
		input [1:0] sense;
		begin
			case (sense)
				`ASP_SENSE_ODD: asp_par = ~^d;
				`ASP_SENSE_EVEN: asp_par = ^d;
				`ASP_SENSE_ONE: asp_par = 1'b1;
				default: asp_par = 1'b0;
			endcase
		end
	endfunction

	// keep only the configured number of data bits
	function [7:0] asp_mask;
		input [7:0] d;
		input [1:0] len;
		begin
			asp_mask = d & (8'hff >> (2'h3 - len));
		end
	endfunction

	reg [7:0] rate_r;
	reg [7:0] fmt_r;
	reg [3:0] mdm_r;
	reg [3:0] err_r;
	reg [2:0] ist_r;
	reg [2:0] imsk_r;
	reg [7:0] rxbuf_r;
	reg rxfull_r;
	reg pready_r;
	reg [31:0] prdata_r;
	reg [10:0] div_r;
	reg tick_r;
	reg rx_s1_r;
	reg rx_s2_r;
	reg rx_s3_r;
	reg tx_st_r;
	reg [10:0] tx_fr_r;
	reg [3:0] tx_idx_r;
	reg [3:0] tx_last_r;
	reg [5:0] tx_cnt_r;
	reg [5:0] tx_stop_r;
	reg [1:0] rx_st_r;
	reg [3:0] rx_cnt_r;
	reg [3:0] rx_idx_r;
	reg [9:0] rx_fr_r;
	reg [31:0] rd_nxt;
	reg [10:0] tx_fr_nxt;
	reg [7:0] rx_data;
	reg rx_perr;
	reg rx_ferr;
	reg rx_brk;
	reg addr_ok;

	wire [5:0] idx = paddr[7:2];
	wire acc = psel & penable & pready_r;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire [3:0] nbits = {2'h0, fmt_r[1:0]} + 4'h5;
	wire pen = fmt_r[`ASP_FMT_PEN];
	wire [1:0] sense = fmt_r[5:4];
	wire tx_busy = (tx_st_r == TX_SEND);
	wire rx_busy = (rx_st_r != RX_IDLE);
	wire soft_rst = wr & (idx == `ASP_IDX_RESET) & (pwdata[7:0] != 8'h00);
	wire tx_load = wr & (idx == `ASP_IDX_TXDATA) & ~tx_busy;
	wire rx_take = rd & (idx == `ASP_IDX_RXDATA);
	wire tx_done = tx_busy & tick_r & (tx_idx_r == tx_last_r) & (tx_cnt_r == tx_stop_r - 6'h01);
	wire rx_end = (rx_st_r == RX_BITS) & tick_r & (rx_cnt_r == 4'hf)
		& (rx_idx_r == nbits + {3'h0, pen});

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pready_r & ~addr_ok;
	assign irq = |(ist_r & imsk_r);
	assign rts = mdm_r[`ASP_MDM_RTS] | tx_busy;
	assign dtr = mdm_r[`ASP_MDM_DTR] | tx_busy | rx_busy;
	assign srts = mdm_r[`ASP_MDM_SRTS];
	assign drs = mdm_r[`ASP_MDM_DRS];

	// read mux and address decode
	always @*
	begin
		rd_nxt = 32'h0000_0000;
		addr_ok = 1'b1;
		case (idx)
			`ASP_IDX_RESET: rd_nxt = 32'h0000_0000;
			`ASP_IDX_TXDATA: rd_nxt = 32'h0000_0000;
			`ASP_IDX_RXDATA: rd_nxt = {24'h0, rxbuf_r};
			`ASP_IDX_RATE: rd_nxt = {24'h0, rate_r};
			`ASP_IDX_FORMAT: rd_nxt = {24'h0, fmt_r};
			`ASP_IDX_MODEM: rd_nxt = {28'h0, mdm_r};
			`ASP_IDX_LSTAT: rd_nxt = {29'h0, rx_busy, rxfull_r, tx_busy};
			`ASP_IDX_ISTAT: rd_nxt = {29'h0, ist_r};
			`ASP_IDX_IMASK: rd_nxt = {29'h0, imsk_r};
			`ASP_IDX_ERR: rd_nxt = {28'h0, err_r};
			default: addr_ok = 1'b0;
		endcase
	end

	// apb: one wait state, data and pready from flops
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= psel & penable & ~pready_r;
			if (psel & penable & ~pready_r & ~pwrite)
				prdata_r <= rd_nxt;
		end
	end

	// configuration registers
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			rate_r <= `ASP_RATE_RST;
			fmt_r <= `ASP_FORMAT_RST;
			mdm_r <= 4'h0;
			imsk_r <= 3'h0;
		end
		else if (soft_rst)
		begin
			rate_r <= `ASP_RATE_RST;
			mdm_r <= 4'h0;
			imsk_r <= 3'h0;
		end
		else if (wr)
		begin
			if (idx == `ASP_IDX_RATE)
				rate_r <= pwdata[7:0];
			if (idx == `ASP_IDX_FORMAT)
				fmt_r <= pwdata[7:0];
			if (idx == `ASP_IDX_MODEM)
				mdm_r <= pwdata[3:0];
			if (idx == `ASP_IDX_IMASK)
				imsk_r <= pwdata[2:0];
		end
	end

	// oversample tick: 16 per bit, every (rate+1)*8 clocks
	always @(posedge sys_clk)
	begin
		if (rst | soft_rst)
		begin
			div_r <= 11'h000;
			tick_r <= 1'b0;
		end
		else if (div_r >= {rate_r, 3'h7})
		begin
			div_r <= 11'h000;
			tick_r <= 1'b1;
		end
		else
		begin
			div_r <= div_r + 11'h001;
			tick_r <= 1'b0;
		end
	end

	// transmit frame: start, data lsb first, parity, stop
	always @*
	begin : txf
		integer i;
		tx_fr_nxt = 11'h7fe;
		for (i = 0; i < 8; i = i + 1)
			if (i < nbits)
				tx_fr_nxt[i + 1] = pwdata[i];
		if (pen)
			tx_fr_nxt[nbits + 4'h1] = asp_par(asp_mask(pwdata[7:0], fmt_r[1:0]), sense);
	end

	// transmitter
	always @(posedge sys_clk)
	begin
		if (rst | soft_rst)
		begin
			tx_st_r <= TX_IDLE;
			txd <= 1'b1;
			tx_fr_r <= 11'h7ff;
			tx_idx_r <= 4'h0;
			tx_last_r <= 4'h0;
			tx_cnt_r <= 6'h00;
			tx_stop_r <= `ASP_STOP1_TICKS;
		end
		else
		begin
			case (tx_st_r)
				TX_IDLE:
				begin
					txd <= 1'b1;
					if (tx_load)
					begin
						tx_st_r <= TX_SEND;
						tx_fr_r <= tx_fr_nxt;
						tx_idx_r <= 4'h0;
						tx_cnt_r <= 6'h00;
						tx_last_r <= nbits + {3'h0, pen} + 4'h1;
						if (!fmt_r[`ASP_FMT_STOP])
							tx_stop_r <= `ASP_STOP1_TICKS;
						else if (fmt_r[1:0] == 2'h0)
							tx_stop_r <= `ASP_STOP15_TICKS;
						else
							tx_stop_r <= `ASP_STOP2_TICKS;
					end
				end
				TX_SEND:
				begin
					txd <= tx_fr_r[tx_idx_r];
					if (tick_r)
					begin
						// done only after final stop tick
						if (tx_done)
							tx_st_r <= TX_IDLE;
						else if (tx_idx_r != tx_last_r && tx_cnt_r == `ASP_OS_TICKS - 6'h01)
						begin
							tx_cnt_r <= 6'h00;
							tx_idx_r <= tx_idx_r + 4'h1;
						end
						else
							tx_cnt_r <= tx_cnt_r + 6'h01;
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// receive line synchroniser; edge detector reads the second and third stage
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
		end
		else
		begin
			rx_s1_r <= rxd;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
		end
	end

	// frame checks on the completed receive frame
	always @*
	begin
		rx_data = asp_mask(rx_fr_r[7:0], fmt_r[1:0]);
		rx_perr = pen & (rx_fr_r[nbits] != asp_par(rx_data, sense));
		rx_ferr = ~rx_s2_r;
		rx_brk = ~rx_s2_r & (rx_fr_r == 10'h000);
	end

	// receiver
	always @(posedge sys_clk)
	begin
		if (rst | soft_rst)
		begin
			rx_st_r <= RX_IDLE;
			rx_cnt_r <= 4'h0;
			rx_idx_r <= 4'h0;
			rx_fr_r <= 10'h000;
		end
		else
		begin
			case (rx_st_r)
				RX_IDLE:
				begin
					rx_cnt_r <= 4'h0;
					rx_idx_r <= 4'h0;
					if (rx_s3_r & ~rx_s2_r)
					begin
						rx_st_r <= RX_START;
						rx_fr_r <= 10'h000;
					end
				end
				RX_START:
					if (tick_r)
					begin
						if (rx_cnt_r == `ASP_HALF_TICKS)
						begin
							rx_cnt_r <= 4'h0;
							rx_st_r <= rx_s2_r ? RX_IDLE : RX_BITS;
						end
						else
							rx_cnt_r <= rx_cnt_r + 4'h1;
					end
				RX_BITS:
					if (tick_r)
					begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == 4'hf)
						begin
							if (rx_end)
								rx_st_r <= RX_IDLE;
							else
								rx_fr_r[rx_idx_r] <= rx_s2_r;
							rx_idx_r <= rx_idx_r + 4'h1;
						end
					end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// receive buffer, error flags and interrupt status; set wins over clear
	always @(posedge sys_clk)
	begin
		if (rst | soft_rst)
		begin
			rxbuf_r <= 8'h00;
			rxfull_r <= 1'b0;
			err_r <= 4'h0;
			ist_r <= 3'h0;
		end
		else
		begin
			if (rx_end)
			begin
				rxbuf_r <= rx_data;
				rxfull_r <= 1'b1;
			end
			else if (rx_take)
				rxfull_r <= 1'b0;
			// per-error sticky bits, cleared by reading
			err_r <= ((rd && idx == `ASP_IDX_ERR) ? 4'h0 : err_r)
				| ({rx_brk, rxfull_r, rx_ferr | rx_brk, rx_perr} & {4{rx_end}});
			ist_r[`ASP_INT_RXERR] <= (rx_end & (rx_perr | rx_ferr | rxfull_r))
				| (ist_r[`ASP_INT_RXERR] & ~(wr && idx == `ASP_IDX_ISTAT
				&& pwdata[`ASP_INT_RXERR]));
			ist_r[`ASP_INT_RXRDY] <= rx_end | (ist_r[`ASP_INT_RXRDY]
				& ~(wr && idx == `ASP_IDX_ISTAT && pwdata[`ASP_INT_RXRDY]));
			ist_r[`ASP_INT_TXDONE] <= tx_done | (ist_r[`ASP_INT_TXDONE]
				& ~(wr && idx == `ASP_IDX_ISTAT && pwdata[`ASP_INT_TXDONE]));
		end
	end
endmodule

/* bench/asp_serial_port_properties.sv */
// pin-level assertions for the serial port, bound to the port module
module asp_serial_port_properties
(
	input wire sys_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire rxd,
	input wire txd,
	input wire rts,
	input wire dtr,
	input wire srts,
	input wire drs,
	input wire irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	wire wr_ok = psel && penable && pready && pwrite && !pslverr;
	wire mdm_w = wr_ok && paddr[7:2] == 6'h05;
	wire rst_w = wr_ok && paddr[7:2] == 6'h00 && pwdata[7:0] != 8'h00;
	property p_rdy;
		pready |=> !pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
	property p_slv;
		pslverr |-> pready;
	endproperty
	a_slv: assert property (p_slv) else $error("error without ready");
	property p_sec;
		mdm_w |=> {drs, srts} == $past(pwdata[3:2]);
	endproperty
	a_sec: assert property (p_sec) else $error("drs or srts wrong");
	property p_hold;
		!$past(wr_ok) |-> $stable({drs, srts});
	endproperty
	a_hold: assert property (p_hold) else $error("drs or srts moved");
	property p_force;
		mdm_w && pwdata[1] && pwdata[0] |=> rts && dtr;
	endproperty
	a_force: assert property (p_force) else $error("rts or dtr not held");
	property p_soft;
		rst_w |=> !rts && !dtr && !srts && !drs && txd;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset left lines up");
	property p_idle;
		!rts |-> txd;
	endproperty
	a_idle: assert property (p_idle) else $error("txd active while idle");
	property p_start;
		$fell(txd) |-> rts[*4];
	endproperty
	a_start: assert property (p_start) else $error("rts low in a frame");
	property p_irq;
		$fell(irq) |-> $past(wr_ok);
	endproperty
	a_irq: assert property (p_irq) else $error("irq dropped by itself");
	c_tx: cover property ($fell(txd));
	c_irq: cover property ($rose(irq));
	c_slv: cover property (pslverr);
endmodule
bind asp_serial_port asp_serial_port_properties i_asp_serial_port_properties
(.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
.rxd(rxd), .txd(txd), .rts(rts), .dtr(dtr), .srts(srts), .drs(drs), .irq(irq));

/* bench/asp_peer.sv */
// serial peripheral model: sends frames on rxd, captures frames from txd
module asp_peer
#(
	parameter int BIT = 128
)
(
	input wire sys_clk,
	output logic rxd,
	input wire txd
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [11:0] got = 12'hfff;
	initial
	begin
		rxd = 1'b1;
		forever
		begin
			@(negedge txd);
			// idle line reads as ones beyond a short frame
			got = 12'hfff;
			repeat (BIT / 2) @(posedge sys_clk);
			// mid-bit samples; twelve cover the longest frame
			for (int i = 0; i < 12; i++)
			begin
				got[i] = txd;
				repeat (BIT) @(posedge sys_clk);
			end
		end
	end
	// one vector so back-to-back frames never drive rxd twice in a step
	task automatic send(input logic [23:0] v, input int nb);
		for (int i = 0; i < nb; i++)
		begin
			rxd <= v[i];
			repeat (BIT) @(posedge sys_clk);
		end
		rxd <= 1'b1;
	endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the serial port
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, rxd, txd, rts, dtr, srts, drs, irq;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] q;
	logic e;
	logic [11:0] f1, f2;
	logic [7:0] fmts [6] = '{8'h00, 8'h0d, 8'h1c, 8'h2a, 8'h3b, 8'h27};
	asp_serial_port i_asp_serial_port (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.rts(rts), .dtr(dtr), .srts(srts), .drs(drs), .irq(irq));
	asp_peer i_asp_peer (.sys_clk(sys_clk), .rxd(rxd), .txd(txd));
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			err_count++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// no wait limit here: only the bench timeout ends a hung access
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		apb(a, 1'b0, 32'h0);
		chk(q, want);
	endtask
	function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d);
		int n;
		logic p;
		n = 5 + f[1:0];
		frame = 12'hffe;
		for (int i = 0; i < n; i++)
			frame[1 + i] = d[i];
		p = ^(d & ~(8'hff << n));
		case (f[5:4])
			2'h0: p = ~p;
			2'h2: p = 1'b1;
			2'h3: p = 1'b0;
			default: p = p;
		endcase
		if (f[3])
			frame[1 + n] = p;
	endfunction
	task automatic tx(input logic [7:0] f);
		int c;
		int h;
		h = 2 * (6 + f[1:0] + f[3]) + (f[2] ? (f[1:0] == 2'h0 ? 3 : 4) : 2);
		c = 1;
		wr(8'h10, {24'h0, f});
		wr(8'h04, 32'ha5);
		// host waits for the last stop bit before anything else
		while (rts === 1'b1 && c < 2000)
		begin
			@(posedge sys_clk);
			c++;
		end
		// first oversample tick lands 1 to 8 clocks after the load
		chk(c >= h * 64 - 8 && c <= h * 64 + 1, 1);
		// let the peer finish all twelve samples before the next frame starts
		repeat (800) @(posedge sys_clk);
		chk(i_asp_peer.got, frame(f, 8'ha5));
		chk(irq, 1);
		wr(8'h20, 32'h0);
		chk(irq, 0);
		wr(8'h1c, 32'h7);
		wr(8'h20, 32'h4);
		chk(irq, 0);
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(8'h0c, 32'h50);
		wr(8'h0c, 32'h0);
		rd(8'h0c, 32'h0);
		apb(8'h24, 1'b0, 32'h0);
		chk({e, q}, 33'h100000000);
		$display("test registers done");
		wr(8'h20, 32'h4);
		foreach (fmts[i])
			tx(fmts[i]);
		$display("test transmit done");
		wr(8'h10, 32'h1b);
		wr(8'h20, 32'h1);
		f1 = frame(8'h1b, 8'h3c);
		i_asp_peer.send({12'hfff, f1}, 11);
		rd(8'h08, 32'h3c);
		rd(8'h28, 32'h0);
		chk(irq, 0);
		i_asp_peer.send({12'hfff, f1 ^ 12'h200}, 11);
		apb(8'h08, 1'b0, 32'h0);
		rd(8'h28, 32'h1);
		chk(irq, 1);
		wr(8'h1c, 32'h7);
		chk(irq, 0);
		i_asp_peer.send({12'hfff, f1 & 12'hbff}, 11);
		apb(8'h08, 1'b0, 32'h0);
		rd(8'h28, 32'h2);
		i_asp_peer.send(24'h0, 11);
		apb(8'h08, 1'b0, 32'h0);
		rd(8'h28, 32'ha);
		f1 = frame(8'h1b, 8'h11);
		f2 = frame(8'h1b, 8'h22);
		i_asp_peer.send({2'h3, f2[10:0], f1[10:0]}, 22);
		rd(8'h28, 32'h4);
		rd(8'h08, 32'h22);
		$display("test receive done");
		wr(8'h14, 32'hf);
		chk({drs, srts, rts, dtr}, 4'hf);
		wr(8'h00, 32'h0);
		chk(srts, 1);
		wr(8'h00, 32'h1);
		chk({drs, srts, rts, dtr}, 4'h0);
		rd(8'h0c, 32'h50);
		rd(8'h10, 32'h1b);
		$display("test modem done");
		final_report();
	end
endmodule
